// file: rtl/cmo_unit.sv
// Purpose: Execute data/instruction cache tag write instructions
// Assumes: Tag arrays accept one write strobe per cycle; memory takes
//          one word per accepted beat
// Notes:   Status/mask/control registers on an AHB-Lite slave
`timescale 1ns/1ps
// Function
// - Privileged dcache op in user mode traps 00111
// - Dcache address is rA+rB with write-back
// - Four-word line: index addr>>4, clear low bits
// - Eight-word line: index addr>>5, clear low bits
// - Flush writes valid dirty words back first
// - Clear option requires matching stored line address
// - Matched clear finishes in two cycles
// - Plain invalidate: three cycles, two area-optimized
// - Flush: two cycles plus write-back cycles
// - Dcache enable flag has no effect
// - Operand address is physical, never translated
// - Icache op uses only first source register
// - Privileged icache op in user mode traps
// - Icache index addr>>4 or >>5, masked, cleared
// - Icache enable flag has no effect
// - Without write-back, always plain invalidate
// - Flush and clear bits from instruction word
module cmo_unit #(
	parameter bit MEMORY_MGMT_PRESENT     = 1'b1,
	parameter bit DCACHE_WRITEBACK_OPTION = 1'b1,
	parameter int DCACHE_WORDS_PER_LINE   = 4,
	parameter int ICACHE_WORDS_PER_LINE   = 4,
	parameter int DCACHE_LINES            = 256,
	parameter int ICACHE_LINES            = 256,
	parameter bit AREA_OPTIMIZED          = 1'b0
) (
	input  wire logic                         hclk,
	input  wire logic                         hresetn,
	// Execute stage
	input  wire logic                         op_valid,
	input  wire logic                         op_is_icache,
	input  wire logic [31:0]                  op_instr,
	input  wire logic [31:0]                  op_ra,
	input  wire logic [31:0]                  op_rb,
	input  wire logic                         user_mode_flag,
	input  wire logic                         dcache_enable_flag,
	input  wire logic                         icache_enable_flag,
	output logic                              op_stall,
	output logic                              op_done,
	output logic                              priv_exception,
	output logic [4:0]                        exception_code_field,
	// Data cache tag array
	output logic [$clog2(DCACHE_LINES)-1:0]   dc_index,
	input  wire logic                         dc_dirty,
	input  wire logic [DCACHE_WORDS_PER_LINE-1:0] dc_word_valid,
	input  wire logic [31:0]                  dc_line_addr,
	input  wire logic [31:0]                  dc_word_data,
	output logic [$clog2(DCACHE_WORDS_PER_LINE)-1:0] dc_word_sel,
	output logic                              dc_tag_clear,
	// Instruction cache tag array
	output logic [$clog2(ICACHE_LINES)-1:0]   ic_index,
	output logic                              ic_tag_clear,
	// Write-back port
	output logic                              wb_valid,
	input  wire logic                         wb_ready,
	output logic [31:0]                       wb_addr,
	output logic [31:0]                       wb_data,
	// AHB-Lite slave
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic [31:0]                       hrdata,
	output logic                              hreadyout,
	output logic                              hresp,
	output logic                              irq
);
	import cmo_pkg::*;

	localparam int DW = $clog2(DCACHE_WORDS_PER_LINE);
	localparam int DI = $clog2(DCACHE_LINES);
	localparam int II = $clog2(ICACHE_LINES);
	localparam int DSH = (DCACHE_WORDS_PER_LINE == 8) ? SHIFT8 : SHIFT4;
	localparam int ISH = (ICACHE_WORDS_PER_LINE == 8) ? SHIFT8 : SHIFT4;

	initial begin
		if (!(DCACHE_WORDS_PER_LINE inside {4, 8}) ||
		    !(ICACHE_WORDS_PER_LINE inside {4, 8}))
			$error("Line length must be 4 or 8 words");
		if (DCACHE_LINES < 2 || ICACHE_LINES < 2)
			$error("Cache needs at least two lines");
	end

	// Instruction word option bits
	logic        opt_flush;
	logic        opt_clear;
	assign opt_flush = op_instr[4];
	assign opt_clear = op_instr[1];

	// Address is used raw; no translation path exists
	logic [31:0] d_addr;
	assign d_addr = DCACHE_WRITEBACK_OPTION ? op_ra + op_rb : op_ra;
	logic [31:0] d_line_addr;
	assign d_line_addr = d_addr & ((DSH == SHIFT8) ? LINE8_MASK
	                                              : LINE4_MASK);

	logic        priv_fail;
	assign priv_fail = op_valid && MEMORY_MGMT_PRESENT &&
	                   user_mode_flag;

	cmo_state_t  state_reg;
	logic [1:0]  cnt_reg;
	logic [1:0]  lat_reg;
	logic        is_ic_reg;
	logic        flush_reg;
	logic        clear_reg;
	logic [31:0] line_addr_reg;
	logic [DI-1:0] dc_index_reg;
	logic [II-1:0] ic_index_reg;
	logic [DCACHE_WORDS_PER_LINE-1:0] pend_reg;
	logic [1:0]  ctrl_reg;
	logic [2:0]  status_reg;
	logic [2:0]  mask_reg;

	// Control bit 0 holds off write-back of flush ops for debug; bit 1 has no effect
	logic        sw_no_flush;
	assign sw_no_flush = ctrl_reg[0];

	logic        accept;
	assign accept = op_valid && state_reg == CMO_IDLE;

	// Lowest valid word still to be written back; ascending order
	logic [DW-1:0] next_word;
	always_comb begin
		next_word = '0;
		for (int i = DCACHE_WORDS_PER_LINE - 1; i >= 0; i--) begin
			if (pend_reg[i])
				next_word = DW'(i);
		end
	end

	// Final beat retires the op, so no cycle is lost after write-back
	logic        wb_last;
	assign wb_last = wb_valid && wb_ready &&
	                 pend_reg == ((DCACHE_WORDS_PER_LINE)'(1) << next_word);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg     <= CMO_IDLE;
			cnt_reg       <= 2'h0;
			lat_reg       <= 2'h0;
			is_ic_reg     <= 1'b0;
			flush_reg     <= 1'b0;
			clear_reg     <= 1'b0;
			line_addr_reg <= 32'h0;
			dc_index_reg  <= '0;
			ic_index_reg  <= '0;
		end else begin
			unique case (state_reg)
			CMO_IDLE: begin
				if (accept && !priv_fail) begin
					state_reg     <= CMO_EXEC;
					cnt_reg       <= 2'h1;
					is_ic_reg     <= op_is_icache;
					// Only the first source register for icache
					ic_index_reg  <= II'(op_ra >> ISH);
					dc_index_reg  <= DI'(d_addr >> DSH);
					line_addr_reg <= d_line_addr;
					// Enable flags are deliberately not consulted
					flush_reg <= DCACHE_WRITEBACK_OPTION &&
					             opt_flush && !sw_no_flush;
					clear_reg <= DCACHE_WRITEBACK_OPTION &&
					             opt_clear;
					if (op_is_icache)
						lat_reg <= 2'(LAT_IC);
					else if (DCACHE_WRITEBACK_OPTION && opt_clear)
						lat_reg <= 2'(LAT_CLEAR);
					else if (DCACHE_WRITEBACK_OPTION && opt_flush)
						lat_reg <= 2'(LAT_FLUSH_BASE);
					else if (AREA_OPTIMIZED)
						lat_reg <= 2'(LAT_INV_AREA);
					else
						lat_reg <= 2'(LAT_INV_FAST);
				end
			end
			CMO_EXEC: begin
				if (flush_reg && !is_ic_reg && dc_dirty &&
				    |dc_word_valid)
					state_reg <= CMO_WB;
				else if (cnt_reg + 2'h1 >= lat_reg)
					state_reg <= CMO_IDLE;
				else
					state_reg <= CMO_WAIT;
				cnt_reg <= cnt_reg + 2'h1;
			end
			CMO_WB: begin
				if (wb_last)
					state_reg <= CMO_IDLE;
			end
			CMO_WAIT: begin
				state_reg <= CMO_IDLE;
			end
			CMO_FIN: begin
				state_reg <= CMO_IDLE;
			end
			default: state_reg <= CMO_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_reg <= '0;
		end else if (state_reg == CMO_EXEC) begin
			pend_reg <= dc_word_valid;
		end else if (wb_valid && wb_ready) begin
			pend_reg[next_word] <= 1'b0;
		end
	end

	assign wb_valid    = state_reg == CMO_WB && |pend_reg;
	assign wb_addr     = line_addr_reg | (32'(next_word) << 2);
	assign wb_data     = dc_word_data;
	assign dc_word_sel = next_word;
	assign dc_index    = dc_index_reg;
	assign ic_index    = ic_index_reg;

	// Tag clear happens in the EXEC cycle or on the last write-back beat; a clear op also needs a line match
	logic        last_beat;
	assign last_beat = (state_reg == CMO_EXEC &&
	                    !(flush_reg && !is_ic_reg && dc_dirty &&
	                      |dc_word_valid)) ||
	                   wb_last;
	assign ic_tag_clear = last_beat && is_ic_reg && state_reg == CMO_EXEC;
	assign dc_tag_clear = last_beat && !is_ic_reg &&
	                      (!clear_reg ||
	                       dc_line_addr == line_addr_reg);

	assign op_stall = op_valid && !op_done;
	assign op_done  = (accept && priv_fail) ||
	                  (state_reg == CMO_EXEC && !(flush_reg && !is_ic_reg &&
	                   dc_dirty && |dc_word_valid) &&
	                   cnt_reg + 2'h1 >= lat_reg) ||
	                  state_reg == CMO_WAIT || wb_last;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			priv_exception       <= 1'b0;
			exception_code_field <= 5'h0;
		end else begin
			priv_exception <= accept && priv_fail;
			if (accept && priv_fail)
				exception_code_field <= EC_PRIV;
		end
	end

	// AHB-Lite slave, zero wait states
	logic        ap_valid_reg;
	logic        ap_write_reg;
	logic [7:0]  ap_addr_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid_reg <= 1'b0;
			ap_write_reg <= 1'b0;
			ap_addr_reg  <= 8'h0;
		end else if (hready) begin
			ap_valid_reg <= hsel && htrans[1];
			ap_write_reg <= hwrite;
			ap_addr_reg  <= haddr[7:0];
		end
	end

	logic        rd_status;
	assign rd_status = ap_valid_reg && !ap_write_reg &&
	                   ap_addr_reg == OFF_STATUS;

	logic [2:0]  events;
	assign events = {wb_last,
	                 accept && priv_fail, op_done && !priv_fail};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= STATUS_RESET;
			mask_reg   <= MASK_RESET;
			ctrl_reg   <= CTRL_RESET;
		end else begin
			// New events win over the clear-on-read
			status_reg <= (rd_status ? 3'h0 : status_reg) | events;
			if (ap_valid_reg && ap_write_reg) begin
				if (ap_addr_reg == OFF_MASK)
					mask_reg <= hwdata[2:0];
				if (ap_addr_reg == OFF_CTRL)
					ctrl_reg <= hwdata[1:0];
			end
		end
	end

	always_comb begin
		hrdata = 32'h0;
		if (ap_valid_reg && !ap_write_reg) begin
			unique case (ap_addr_reg)
			OFF_STATUS: hrdata = {29'h0, status_reg};
			OFF_MASK:   hrdata = {29'h0, mask_reg};
			OFF_CTRL:   hrdata = {30'h0, ctrl_reg};
			OFF_STATE:  hrdata = {29'h0, state_reg};
			default:    hrdata = 32'h0;
			endcase
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign irq       = |(status_reg & mask_reg);
endmodule

// file: rtl/cmo_pkg.sv
// Purpose: Shared constants for the cache maintenance unit
// Assumes: 32-bit addresses, 100 MHz core clock
// Notes:   Register offsets are byte addresses on the AHB-Lite slave
package cmo_pkg;
	localparam logic [4:0]  EC_PRIV        = 5'h07;
	localparam logic [31:0] LINE4_MASK     = 32'h0ffffff0;
	localparam logic [31:0] LINE8_MASK     = 32'h0fffffe0;
	localparam int          SHIFT4         = 4;
	localparam int          SHIFT8         = 5;
	localparam int          LAT_CLEAR      = 2;
	localparam int          LAT_INV_AREA   = 2;
	localparam int          LAT_INV_FAST   = 3;
	localparam int          LAT_FLUSH_BASE = 2;
	localparam int          LAT_IC         = 2;
	localparam logic [7:0]  OFF_STATUS     = 8'h00;
	localparam logic [7:0]  OFF_MASK       = 8'h04;
	localparam logic [7:0]  OFF_CTRL       = 8'h08;
	localparam logic [7:0]  OFF_STATE      = 8'h0c;
	localparam logic [2:0]  STATUS_RESET   = 3'h0;
	localparam logic [2:0]  MASK_RESET     = 3'h0;
	localparam logic [1:0]  CTRL_RESET     = 2'h0;
	localparam int          ST_DONE        = 0;
	localparam int          ST_PRIV        = 1;
	localparam int          ST_WB          = 2;
	typedef enum logic [2:0] {
		CMO_IDLE  = 3'b000,
		CMO_EXEC  = 3'b001,
		CMO_WB    = 3'b011,
		CMO_WAIT  = 3'b010,
		CMO_FIN   = 3'b110
	} cmo_state_t;
endpackage

// file: verif/cmo_mem_model.sv
// Purpose: Memory side of the write-back port
// Assumes: One word taken per valid-and-ready edge
// Notes:   Slow mode stalls every other cycle
`timescale 1ns/1ps
module cmo_mem_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        wb_valid,
	input  wire logic [31:0] wb_data,
	input  wire logic        slow,
	output logic             wb_ready,
	output int               beats,
	output logic [31:0]      last_data
);
	// Ready does not wait for valid, so stalls hit mid-line too
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wb_ready <= 1'b0;
			beats <= 0;
			last_data <= 32'h0;
		end else begin
			wb_ready <= slow ? ~wb_ready : 1'b1;
			if (wb_valid && wb_ready) begin
				beats <= beats + 1;
				last_data <= wb_data;
			end
		end
	end
endmodule

// file: verif/cmo_unit_monitor.sv
// Purpose: Port checker for the cache maintenance unit
// Assumes: Four-word data lines
// Notes:   Latencies counted from the accept cycle
`timescale 1ns/1ps
module cmo_unit_monitor import cmo_pkg::*; #(
	parameter int DCACHE_LINES = 256,
	parameter int ICACHE_LINES = 256
) (
	input wire logic                            hclk,
	input wire logic                            hresetn,
	input wire logic                            op_valid,
	input wire logic                            op_is_icache,
	input wire logic [31:0]                     op_instr,
	input wire logic [31:0]                     op_ra,
	input wire logic [31:0]                     op_rb,
	input wire logic                            user_mode_flag,
	input wire logic                            op_done,
	input wire logic                            priv_exception,
	input wire logic [4:0]                      exception_code_field,
	input wire logic [$clog2(DCACHE_LINES)-1:0] dc_index,
	input wire logic                            dc_dirty,
	input wire logic [31:0]                     dc_line_addr,
	input wire logic                            dc_tag_clear,
	input wire logic [$clog2(ICACHE_LINES)-1:0] ic_index,
	input wire logic                            ic_tag_clear,
	input wire logic                            wb_valid,
	input wire logic                            wb_ready,
	input wire logic [31:0]                     wb_addr,
	input wire logic [31:0]                     wb_data
);
	localparam int DW = $clog2(DCACHE_LINES);
	localparam int IW = $clog2(ICACHE_LINES);
	int  cnt;
	int  wbc;
	wire dc = op_valid && !op_is_icache && !user_mode_flag;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 0;
			wbc <= 0;
		end else begin
			cnt <= (op_valid && !op_done) ? cnt + 1 : 0;
			wbc <= op_done ? 0 : wbc + int'(wb_valid);
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_trap_code: assert property ($rose(priv_exception) |->
		exception_code_field == EC_PRIV) else $error("bad trap code");
	a_trap_quiet: assert property (op_valid && user_mode_flag && op_done
		|-> (!dc_tag_clear && !ic_tag_clear && !wb_valid) ##1 priv_exception)
		else $error("trap wrote state or no exception");
	a_dc_index: assert property (dc && dc_tag_clear |->
		dc_index == DW'((op_ra + op_rb) >> SHIFT4)) else $error("dc index");
	a_ic_index: assert property (ic_tag_clear |->
		ic_index == IW'(op_ra >> SHIFT4)) else $error("ic index");
	a_wb_cause: assert property (wb_valid |->
		dc && op_instr[4] && dc_dirty) else $error("stray write-back");
	a_wb_hold: assert property (wb_valid && !wb_ready |=>
		wb_valid && $stable(wb_addr) && $stable(wb_data))
		else $error("beat dropped");
	a_clear_match: assert property (dc && dc_tag_clear && op_instr[1]
		&& !op_instr[4] |-> dc_line_addr == ((op_ra + op_rb) & LINE4_MASK))
		else $error("clear without match");
	a_clear_lat: assert property (dc && op_done && op_instr[1]
		&& !op_instr[4] |-> cnt == LAT_CLEAR - 1) else $error("clear latency");
	a_inv_lat: assert property (dc && op_done && !op_instr[1]
		&& !op_instr[4] |-> cnt == LAT_INV_FAST - 1) else $error("inv latency");
	a_flush_lat: assert property (dc && op_done && op_instr[4] |->
		cnt == LAT_FLUSH_BASE - 1 + wbc + int'(wb_valid))
		else $error("flush latency");
	c_stall: cover property (wb_valid && !wb_ready);
	c_trap: cover property (priv_exception);
	c_clear: cover property (dc && dc_tag_clear && op_instr[1]);
endmodule
bind cmo_unit cmo_unit_monitor #(.DCACHE_LINES(DCACHE_LINES),
	.ICACHE_LINES(ICACHE_LINES)) i_mon (.*);

// file: verif/cmo_unit_tb.sv
// Purpose: Self-checking bench for the cache maintenance unit
// Assumes: Default build, four-word lines, 256 lines
// Notes:   Word data encodes the word index for order checks
`timescale 1ns/1ps
module cmo_unit_tb;
	import cmo_pkg::*;
	logic        hclk = 0, hresetn = 0, op_valid = 0, op_is_icache = 0;
	logic        user_mode_flag = 0, dcache_enable_flag = 0, slow = 0;
	logic        icache_enable_flag = 0, dc_dirty = 0, hsel = 0, hwrite = 0;
	logic [31:0] op_instr = 0, op_ra = 0, op_rb = 0, dc_line_addr = 0;
	logic [31:0] haddr = 0, hwdata = 0, wb_addr, wb_data, hrdata, rd;
	logic [31:0] dc_word_data, last_data;
	logic [3:0]  dc_word_valid = 0;
	logic [2:0]  hsize = 3'h2;
	logic [1:0]  htrans = 0, dc_word_sel;
	logic [7:0]  dc_index, ic_index, idx;
	logic [4:0]  exception_code_field;
	logic        op_stall, op_done, priv_exception, dc_tag_clear, ic_tag_clear;
	logic        wb_valid, wb_ready, hreadyout, hresp, irq, hready, clr, pe;
	int          n_errors = 0, samples_checked = 0, beats, lat, nw, b0;
	always #5 hclk = ~hclk;
	assign hready = hreadyout;
	assign dc_word_data = 32'h0000a000 | 32'(dc_word_sel);
	cmo_unit i_dut (.*);
	cmo_mem_model i_mem (.*);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task op(input logic ic, um, input logic [31:0] ins, a, b);
		@(posedge hclk);
		{op_valid, op_is_icache, user_mode_flag} <= {1'b1, ic, um};
		{op_instr, op_ra, op_rb} <= {ins, a, b};
		{lat, nw, clr, b0} = {32'd0, 32'd0, 1'b0, beats};
		do begin
			@(negedge hclk);
			lat++;
			nw += int'(wb_valid);
			if (dc_tag_clear || ic_tag_clear) begin
				clr = 1;
				idx = ic ? ic_index : dc_index;
			end
		end while (op_done !== 1'b1 && lat < 60);
		@(posedge hclk);
		op_valid <= 0;
		@(negedge hclk);
		pe = priv_exception;
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
		do @(negedge hclk); while (hreadyout !== 1'b1);
		@(posedge hclk);
		{htrans, hwdata} <= {2'h0, d};
		do begin
			@(negedge hclk);
			rd = hrdata;
		end while (hreadyout !== 1'b1);
		@(posedge hclk);
		hsel <= 0;
	endtask
	task t_regs;
		foreach (rd[i]) if (i < 4) begin
			ahb(0, 8'(i * 4), 0);
			chk(rd, 0);
		end
		ahb(1, 8'h1c, 32'hffffffff);
		ahb(0, 8'h1c, 0);
		chk(rd, 0);
	endtask
	task t_inv;
		dc_dirty <= 1;
		for (int e = 0; e < 2; e++) begin
			dcache_enable_flag <= e[0];
			op(0, 0, 32'h0, 32'h1230, 32'h0100);
			chk(32'(lat), 32'd3);
			chk(32'(clr), 32'd1);
			chk(32'(idx), 32'h33);
			chk(32'(beats - b0), 0);
		end
	endtask
	task t_clear;
		dc_line_addr <= 32'h4040;
		op(0, 0, 32'h2, 32'h4000, 32'h0048);
		chk(32'(lat), 32'd2);
		chk(32'(clr), 32'd1);
		dc_line_addr <= 32'h5040;
		op(0, 0, 32'h2, 32'h4000, 32'h0048);
		chk(32'(clr), 32'd0);
	endtask
	task t_flush;
		{dc_dirty, dc_word_valid, slow} <= {1'b1, 4'b1011, 1'b1};
		op(0, 0, 32'h10, 32'h200, 32'h0);
		chk(32'(beats - b0), 32'd3);
		chk(last_data, 32'ha003);
		chk(32'(lat), 32'(2 + nw));
		dc_dirty <= 0;
		op(0, 0, 32'h10, 32'h200, 32'h0);
		chk(32'(lat), 32'd2);
		chk(32'(clr), 32'd1);
	endtask
	task t_ic;
		icache_enable_flag <= 1;
		op(1, 0, 32'h0, 32'h0570, 32'hfffffff0);
		chk(32'(idx), 32'h57);
		chk(32'(lat), 32'd2);
	endtask
	task t_trap;
		dc_dirty <= 1;
		op(0, 1, 32'h10, 32'h300, 32'h0);
		chk(32'(pe), 32'd1);
		chk(32'(exception_code_field), 32'h07);
		chk(32'(clr) | 32'(beats - b0), 0);
		op(1, 1, 32'h0, 32'h300, 32'h0);
		chk(32'(pe), 32'd1);
	endtask
	task t_irq;
		ahb(0, 8'h00, 0);
		ahb(1, 8'h04, 32'h1);
		op(0, 0, 32'h0, 32'h40, 32'h0);
		chk(32'(irq), 32'd1);
		ahb(0, 8'h00, 0);
		chk(rd, 32'h1);
		@(negedge hclk);
		chk(32'(irq), 32'd0);
		ahb(1, 8'h04, 32'h0);
		op(0, 0, 32'h0, 32'h40, 32'h0);
		chk(32'(irq), 32'd0);
	endtask
	task print_verdict;
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1;
		t_regs;
		t_inv;
		t_clear;
		t_flush;
		t_ic;
		t_trap;
		t_irq;
		print_verdict;
	end
	// Whole run needs about a hundred cycles; this is far beyond it
	initial begin
		#200000;
		n_errors++;
		print_verdict;
	end
endmodule
